// ===== pack_sup_pkg.sv
package pack_sup_pkg;

    // clock and 1 s poll period
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned POLL_PERIOD_NS = 1000000000;
    localparam int unsigned POLL_CYCLES = POLL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned POLL_CNT_W = 25;

    // coulomb counter: one lsb is 0.26 nVh of sense signal
    localparam int unsigned COUNT_W = 32;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_EOFF_TIMEOUT = 8'h04;
    localparam logic [7:0] ADDR_TRIP_SET = 8'h08;
    localparam logic [7:0] ADDR_TRIP_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_BAL_THRESH = 8'h10;
    localparam logic [7:0] ADDR_TEMP_MIN = 8'h14;
    localparam logic [7:0] ADDR_TEMP_MAX = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_COUNT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;

    // control register fields
    localparam int unsigned CTRL_TRIP_EN_BIT = 0;
    localparam int unsigned CTRL_BAL_EN_BIT = 1;

    // interrupt status bits
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_EOFF_OFF = 0;
    localparam int unsigned IRQ_EOFF_ON = 1;
    localparam int unsigned IRQ_TRIP = 2;
    localparam int unsigned IRQ_SYSTEM_PRESENT_N = 3;
    localparam int unsigned IRQ_INHIBIT = 4;

    // reset values
    localparam logic [15:0] RST_EOFF_TIMEOUT = 16'h003C;
    localparam logic [15:0] RST_TRIP_SET = 16'h0100;
    localparam logic [15:0] RST_TRIP_CLEAR = 16'h0200;
    localparam logic [15:0] RST_BAL_THRESH = 16'h0FA0;
    localparam logic [15:0] RST_TEMP_MIN = 16'h0000;
    localparam logic [15:0] RST_TEMP_MAX = 16'h01C2;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 5'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic trip_en;
        logic bal_en;
        logic [15:0] eoff_timeout;
        logic [15:0] trip_set;
        logic [15:0] trip_clear;
        logic [15:0] bal_thresh;
        logic signed [15:0] temp_min;
        logic signed [15:0] temp_max;
    } cfg_t;

    typedef struct packed {
        logic inhibit;
        logic balancing;
        logic trip_flag;
        logic dsg_act;
        logic chg_act;
        logic fets_on;
        logic present;
    } status_t;

    typedef enum logic [0:0] {
        EOFF_ON = 1'b0,
        EOFF_OFF = 1'b1
    } eoff_state_t;

    // byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) res[7:0] = data[7:0];
        if (strb[1]) res[15:8] = data[15:8];
        return res;
    endfunction

endpackage

// ===== pack_supervisor_events.sv
`timescale 1ns/1ps
module pack_supervisor_events #(
    parameter int unsigned POLL_CYCLES = pack_sup_pkg::POLL_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic system_present_n,
    input wire logic emergency_off_button,
    input wire logic signed [15:0] sense_pos,
    input wire logic signed [15:0] sense_neg,
    input wire logic sense_valid,
    input wire logic [15:0] cell_voltage,
    input wire logic signed [15:0] pack_temp,
    input wire logic [15:0] remaining_capacity_value,
    output logic charge_fet_drive,
    output logic discharge_fet_drive,
    output logic charge_activity,
    output logic discharge_activity,
    output logic balance_enable,
    output logic charge_inhibit,
    output logic trip_interrupt_pin_o,
    output logic trip_interrupt_pin_oe,
    output logic trip_pullup_en,
    output logic irq
);

    localparam int unsigned POLL_CNT_W = pack_sup_pkg::POLL_CNT_W;
    localparam int unsigned COUNT_W = pack_sup_pkg::COUNT_W;

    // bus slave state
    logic [7:0] aw_addr, next_aw_addr;
    logic aw_full, next_aw_full;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic w_full, next_w_full;
    logic [1:0] bresp, next_bresp;
    logic bvalid, next_bvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic rvalid, next_rvalid;
    logic wr_go, rd_go;

    // configuration and interrupts
    pack_sup_pkg::cfg_t cfg, next_cfg;
    logic [pack_sup_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [pack_sup_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [pack_sup_pkg::IRQ_W-1:0] events;
    logic irq_out, next_irq_out;

    // pin synchronisers and supervisor state
    logic system_present_n_meta, system_present_n_sync, eoff_meta, eoff_sync, eoff_prev;
    logic [pack_sup_pkg::POLL_CNT_W-1:0] poll_cnt, next_poll_cnt;
    logic poll_tick;
    pack_sup_pkg::eoff_state_t eoff_state, next_eoff_state;
    logic [15:0] eoff_cnt, next_eoff_cnt;
    logic eoff_fall, eoff_expire;
    pack_sup_pkg::status_t st, next_st;
    logic [pack_sup_pkg::COUNT_W-1:0] coulomb_count, next_coulomb_count;
    logic signed [16:0] diff;
    logic trip_oe, next_trip_oe;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    assign s_axi_bresp = bresp;
    assign s_axi_bvalid = bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign s_axi_rvalid = rvalid;
    assign wr_go = aw_full && w_full && !bvalid;
    assign rd_go = s_axi_arvalid && !rvalid;

    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_full = aw_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_w_full = w_full;
        next_bresp = bresp;
        next_bvalid = bvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_rvalid = rvalid;
        if (s_axi_awvalid && !aw_full) begin
            next_aw_addr = s_axi_awaddr;
            next_aw_full = 1'b1;
        end
        if (s_axi_wvalid && !w_full) begin
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_w_full = 1'b1;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_go) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = pack_sup_pkg::RESP_OKAY;
            if (aw_addr[1:0] != 2'h0 || aw_addr > pack_sup_pkg::ADDR_IRQ_MASK) begin
                next_bresp = pack_sup_pkg::RESP_SLVERR;
            end
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp = pack_sup_pkg::RESP_OKAY;
            next_rdata = 32'h00000000;
            unique case (s_axi_araddr)
                pack_sup_pkg::ADDR_CTRL: begin
                    next_rdata[pack_sup_pkg::CTRL_TRIP_EN_BIT] = cfg.trip_en;
                    next_rdata[pack_sup_pkg::CTRL_BAL_EN_BIT] = cfg.bal_en;
                end
                pack_sup_pkg::ADDR_EOFF_TIMEOUT: next_rdata[15:0] = cfg.eoff_timeout;
                pack_sup_pkg::ADDR_TRIP_SET: next_rdata[15:0] = cfg.trip_set;
                pack_sup_pkg::ADDR_TRIP_CLEAR: next_rdata[15:0] = cfg.trip_clear;
                pack_sup_pkg::ADDR_BAL_THRESH: next_rdata[15:0] = cfg.bal_thresh;
                pack_sup_pkg::ADDR_TEMP_MIN: next_rdata[15:0] = cfg.temp_min;
                pack_sup_pkg::ADDR_TEMP_MAX: next_rdata[15:0] = cfg.temp_max;
                pack_sup_pkg::ADDR_STATUS: next_rdata[6:0] = st;
                pack_sup_pkg::ADDR_COUNT: next_rdata = coulomb_count;
                pack_sup_pkg::ADDR_IRQ_STATUS: next_rdata[pack_sup_pkg::IRQ_W-1:0] = irq_stat;
                pack_sup_pkg::ADDR_IRQ_MASK: next_rdata[pack_sup_pkg::IRQ_W-1:0] = irq_mask;
                default: next_rresp = pack_sup_pkg::RESP_SLVERR;
            endcase
        end
    end

    // register writes and sticky interrupt status
    always_comb begin
        next_cfg = cfg;
        next_irq_mask = irq_mask;
        if (wr_go) begin
            unique case (aw_addr)
                pack_sup_pkg::ADDR_CTRL: begin
                    if (w_strb[0]) begin
                        next_cfg.trip_en = w_data[pack_sup_pkg::CTRL_TRIP_EN_BIT];
                        next_cfg.bal_en = w_data[pack_sup_pkg::CTRL_BAL_EN_BIT];
                    end
                end
                pack_sup_pkg::ADDR_EOFF_TIMEOUT:
                    next_cfg.eoff_timeout = pack_sup_pkg::merge16(cfg.eoff_timeout, w_data, w_strb);
                pack_sup_pkg::ADDR_TRIP_SET:
                    next_cfg.trip_set = pack_sup_pkg::merge16(cfg.trip_set, w_data, w_strb);
                pack_sup_pkg::ADDR_TRIP_CLEAR:
                    next_cfg.trip_clear = pack_sup_pkg::merge16(cfg.trip_clear, w_data, w_strb);
                pack_sup_pkg::ADDR_BAL_THRESH:
                    next_cfg.bal_thresh = pack_sup_pkg::merge16(cfg.bal_thresh, w_data, w_strb);
                pack_sup_pkg::ADDR_TEMP_MIN:
                    next_cfg.temp_min = pack_sup_pkg::merge16(cfg.temp_min, w_data, w_strb);
                pack_sup_pkg::ADDR_TEMP_MAX:
                    next_cfg.temp_max = pack_sup_pkg::merge16(cfg.temp_max, w_data, w_strb);
                pack_sup_pkg::ADDR_IRQ_MASK: begin
                    if (w_strb[0]) begin
                        next_irq_mask = w_data[pack_sup_pkg::IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // read clears, a same-cycle event still sets
        next_irq_stat = irq_stat;
        if (rd_go && s_axi_araddr == pack_sup_pkg::ADDR_IRQ_STATUS) begin
            next_irq_stat = '0;
        end
        next_irq_stat = next_irq_stat | events;
        next_irq_out = |(next_irq_stat & next_irq_mask);
    end

    always_comb begin
        events = '0;
        events[pack_sup_pkg::IRQ_EOFF_OFF] = next_eoff_state == pack_sup_pkg::EOFF_OFF
            && eoff_state == pack_sup_pkg::EOFF_ON;
        events[pack_sup_pkg::IRQ_EOFF_ON] = next_eoff_state == pack_sup_pkg::EOFF_ON
            && eoff_state == pack_sup_pkg::EOFF_OFF;
        events[pack_sup_pkg::IRQ_TRIP] = next_st.trip_flag && !st.trip_flag;
        events[pack_sup_pkg::IRQ_SYSTEM_PRESENT_N] = next_st.present != st.present;
        events[pack_sup_pkg::IRQ_INHIBIT] = next_st.inhibit && !st.inhibit;
    end

    // 1 s poll tick
    assign poll_tick = poll_cnt == POLL_CNT_W'(POLL_CYCLES - 1);

    assign eoff_fall = eoff_prev && !eoff_sync;
    assign eoff_expire = poll_tick && cfg.eoff_timeout != 16'h0000
        && (eoff_cnt + 16'h0001) >= cfg.eoff_timeout;
    assign diff = 17'(sense_pos) - 17'(sense_neg);

    always_comb begin
        next_poll_cnt = poll_tick ? '0 : poll_cnt + 1'b1;
        next_eoff_state = eoff_state;
        next_eoff_cnt = eoff_cnt;
        unique case (eoff_state)
            pack_sup_pkg::EOFF_ON: begin
                if (eoff_fall) begin
                    next_eoff_state = pack_sup_pkg::EOFF_OFF;
                    next_eoff_cnt = 16'h0000;
                end
            end
            pack_sup_pkg::EOFF_OFF: begin
                if (eoff_fall || eoff_expire) begin
                    next_eoff_state = pack_sup_pkg::EOFF_ON;
                end else if (poll_tick) begin
                    next_eoff_cnt = eoff_cnt + 16'h0001;
                end
            end
        endcase
        next_st = st;
        if (poll_tick) begin
            next_st.present = !system_present_n_sync;
        end
        next_st.fets_on = next_eoff_state == pack_sup_pkg::EOFF_ON;
        if (sense_valid) begin
            next_st.chg_act = diff > 17'sd0;
            next_st.dsg_act = diff < 17'sd0;
        end
        next_coulomb_count = coulomb_count;
        if (sense_valid) begin
            next_coulomb_count = coulomb_count + COUNT_W'(diff);
        end
        // set at low threshold, clear at high threshold
        if (!cfg.trip_en) begin
            next_st.trip_flag = 1'b0;
        end else if (remaining_capacity_value <= cfg.trip_set) begin
            next_st.trip_flag = 1'b1;
        end else if (remaining_capacity_value >= cfg.trip_clear) begin
            next_st.trip_flag = 1'b0;
        end
        next_trip_oe = next_st.trip_flag;
        // balance only while charging above threshold
        next_st.balancing = cfg.bal_en && st.chg_act && cell_voltage > cfg.bal_thresh;
        next_st.inhibit = pack_temp < cfg.temp_min || pack_temp > cfg.temp_max;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_addr <= 8'h00;
            aw_full <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            w_full <= 1'b0;
            bresp <= pack_sup_pkg::RESP_OKAY;
            bvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= pack_sup_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            cfg <= '{trip_en: 1'b0, bal_en: 1'b0,
                     eoff_timeout: pack_sup_pkg::RST_EOFF_TIMEOUT,
                     trip_set: pack_sup_pkg::RST_TRIP_SET,
                     trip_clear: pack_sup_pkg::RST_TRIP_CLEAR,
                     bal_thresh: pack_sup_pkg::RST_BAL_THRESH,
                     temp_min: pack_sup_pkg::RST_TEMP_MIN,
                     temp_max: pack_sup_pkg::RST_TEMP_MAX};
            irq_stat <= '0;
            irq_mask <= pack_sup_pkg::RST_IRQ_MASK;
            irq_out <= 1'b0;
            system_present_n_meta <= 1'b1;
            system_present_n_sync <= 1'b1;
            eoff_meta <= 1'b1;
            eoff_sync <= 1'b1;
            eoff_prev <= 1'b1;
            poll_cnt <= '0;
            eoff_state <= pack_sup_pkg::EOFF_ON;
            eoff_cnt <= 16'h0000;
            st <= '{fets_on: 1'b1, default: 1'b0};
            coulomb_count <= '0;
            trip_oe <= 1'b0;
        end else begin
            aw_addr <= next_aw_addr;
            aw_full <= next_aw_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            w_full <= next_w_full;
            bresp <= next_bresp;
            bvalid <= next_bvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            rvalid <= next_rvalid;
            cfg <= next_cfg;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq_out <= next_irq_out;
            system_present_n_meta <= system_present_n;
            system_present_n_sync <= system_present_n_meta;
            eoff_meta <= emergency_off_button;
            eoff_sync <= eoff_meta;
            eoff_prev <= eoff_sync;
            poll_cnt <= next_poll_cnt;
            eoff_state <= next_eoff_state;
            eoff_cnt <= next_eoff_cnt;
            st <= next_st;
            coulomb_count <= next_coulomb_count;
            trip_oe <= next_trip_oe;
        end
    end

    assign charge_fet_drive = st.fets_on && !st.inhibit;
    assign discharge_fet_drive = st.fets_on;
    assign charge_activity = st.chg_act;
    assign discharge_activity = st.dsg_act;
    assign balance_enable = st.balancing;
    assign charge_inhibit = st.inhibit;
    assign trip_interrupt_pin_o = 1'b0;
    assign trip_interrupt_pin_oe = trip_oe;
    assign trip_pullup_en = cfg.trip_en;
    assign irq = irq_out;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_fall_while_on;
        eoff_fall && eoff_state == pack_sup_pkg::EOFF_ON;
    endsequence
    sequence s_fets_dropped;
        !discharge_fet_drive && !charge_fet_drive;
    endsequence

    property p_eoff_off;
        s_fall_while_on |=> s_fets_dropped;
    endproperty
    a_eoff_off: assert property (p_eoff_off) else $error("fets not off after press");

    property p_eoff_press_on;
        eoff_fall && eoff_state == pack_sup_pkg::EOFF_OFF |=> discharge_fet_drive;
    endproperty
    a_eoff_press_on: assert property (p_eoff_press_on) else $error("second press ignored");

    property p_eoff_timeout;
        eoff_state == pack_sup_pkg::EOFF_OFF && eoff_expire |=> discharge_fet_drive;
    endproperty
    a_eoff_timeout: assert property (p_eoff_timeout) else $error("timeout did not re-enable");

    property p_timer_restart;
        s_fall_while_on |=> eoff_cnt == 16'h0000 ##1 eoff_cnt <= 16'h0001;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

    property p_present;
        poll_tick |=> st.present == !$past(system_present_n_sync);
    endproperty
    a_present: assert property (p_present) else $error("presence sample wrong");

    property p_activity;
        sense_valid && diff > 17'sd0 |=> charge_activity && !discharge_activity;
    endproperty
    a_activity: assert property (p_activity) else $error("charge activity not reported");

    property p_counter;
        sense_valid |=> coulomb_count == $past(coulomb_count) + COUNT_W'($past(diff));
    endproperty
    a_counter: assert property (p_counter) else $error("counter did not integrate");

    property p_trip_pin;
        cfg.trip_en && remaining_capacity_value <= cfg.trip_set |=> trip_interrupt_pin_oe;
    endproperty
    a_trip_pin: assert property (p_trip_pin) else $error("trip pin not asserted");

    property p_pullup;
        !cfg.trip_en |-> !trip_pullup_en ##1 !trip_interrupt_pin_oe;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up on while disabled");

    property p_balance;
        balance_enable |-> $past(charge_activity) && $past(cell_voltage) > $past(cfg.bal_thresh);
    endproperty
    a_balance: assert property (p_balance) else $error("balancing outside charge");

    property p_inhibit;
        pack_temp > cfg.temp_max |=> charge_inhibit && !charge_fet_drive;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("charging not inhibited");

    property p_edge;
        $past(emergency_off_button, 2) && !$past(emergency_off_button) |=> eoff_fall;
    endproperty
    a_edge: assert property (p_edge) else $error("edge not detected");

endmodule // pack_supervisor_events

// ===== pack_host_model.sv
`timescale 1ns/1ps
module pack_host_model (
    input wire logic present_req,
    input wire logic trip_interrupt_pin_o,
    input wire logic trip_interrupt_pin_oe,
    output logic system_present_n,
    output logic trip_level
);
    assign system_present_n = present_req ? 1'h0 : 1'h1;
    assign trip_level = trip_interrupt_pin_oe ? trip_interrupt_pin_o : 1'h1;
endmodule // pack_host_model

// ===== pack_supervisor_events_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module pack_supervisor_events_bench;
    logic core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, sense_valid, system_present_n, emergency_off_button;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, cnt_exp;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic signed [15:0] sense_pos, sense_neg, pack_temp;
    logic [15:0] cell_voltage, remaining_capacity_value;
    logic charge_fet_drive, discharge_fet_drive, charge_activity, discharge_activity;
    logic balance_enable, charge_inhibit, trip_interrupt_pin_o, trip_interrupt_pin_oe;
    logic trip_pullup_en, irq, present_req, trip_level;
    int err_count, checks, seed;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h28};
    logic [31:0] rv [8] = '{32'h0, 32'h3C, 32'h100, 32'h200, 32'hFA0, 32'h0, 32'h1C2, 32'h0};

    pack_supervisor_events #(.POLL_CYCLES(16)) uut (.core_clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .system_present_n, .emergency_off_button, .sense_pos, .sense_neg,
        .sense_valid, .cell_voltage, .pack_temp, .remaining_capacity_value,
        .charge_fet_drive, .discharge_fet_drive, .charge_activity, .discharge_activity,
        .balance_enable, .charge_inhibit, .trip_interrupt_pin_o, .trip_interrupt_pin_oe,
        .trip_pullup_en, .irq);
    pack_host_model host (.present_req, .trip_interrupt_pin_o, .trip_interrupt_pin_oe,
        .system_present_n, .trip_level);

    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // handshakes sampled just before the edge that takes them
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        int k;
        bh = 1'h0;
        k = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!bh && k < 200) begin
            @(negedge core_clk);
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            bh = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge core_clk);
            if (ah) s_axi_awvalid <= 1'h0;
            if (wh) s_axi_wvalid <= 1'h0;
            if (bh) s_axi_bready <= 1'h0;
            k++;
        end
        if (!bh) err_count++;
    endtask

    task automatic axr(input logic [7:0] a);
        logic ah, rh;
        int k;
        rh = 1'h0;
        k = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!rh && k < 200) begin
            @(negedge core_clk);
            ah = s_axi_arvalid & s_axi_arready;
            rh = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge core_clk);
            if (ah) s_axi_arvalid <= 1'h0;
            if (rh) s_axi_rready <= 1'h0;
            k++;
        end
        if (!rh) err_count++;
    endtask

    task automatic sense(input int p, input int q);
        @(posedge core_clk);
        sense_pos <= 16'(p);
        sense_neg <= 16'(q);
        sense_valid <= 1'h1;
        @(posedge core_clk);
        sense_valid <= 1'h0;
        cnt_exp = cnt_exp + 32'(p - q);
        wt(1);
        `CHK("activity", {p > q, p < q}, {charge_activity, discharge_activity})
    endtask

    task automatic button(input logic v, input logic [1:0] e);
        @(posedge core_clk);
        emergency_off_button <= v;
        wt(6);
        `CHK("fet drives", e, {charge_fet_drive, discharge_fet_drive})
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        test_done();
    end

    initial begin
        {sys_rst, emergency_off_button, s_axi_wstrb} = 6'h3F;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sense_valid, present_req} = 50'h0;
        {sense_pos, sense_neg, cell_voltage} = 48'h0;
        pack_temp = 16'h0019;
        remaining_capacity_value = 16'h0300;
        seed = 32'h902acda0;
        cnt_exp = 32'h0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            axr(ra[i]);
            `CHK("reset value", rv[i], rd)
        end
        axr(8'h2C);
        `CHK("unmapped read", 34'h200000000, {rs, rd})
        axw(8'h2C, 32'h1);
        `CHK("unmapped write", pack_sup_pkg::RESP_SLVERR, rs)
        axw(8'h06, 32'h1);
        `CHK("misaligned write", pack_sup_pkg::RESP_SLVERR, rs)
        $display("registers done");
        @(posedge core_clk);
        present_req <= 1'h1;
        wt(20);
        axr(pack_sup_pkg::ADDR_STATUS);
        `CHK("present", 1'h1, rd[0])
        button(1'h0, 2'h0);
        button(1'h1, 2'h0);
        button(1'h0, 2'h3);
        axw(pack_sup_pkg::ADDR_EOFF_TIMEOUT, 32'h2);
        button(1'h1, 2'h3);
        button(1'h0, 2'h0);
        wt(40);
        `CHK("timeout", 2'h3, {charge_fet_drive, discharge_fet_drive})
        axr(pack_sup_pkg::ADDR_IRQ_STATUS);
        `CHK("fet events", 2'h3, rd[1:0])
        axr(pack_sup_pkg::ADDR_IRQ_STATUS);
        `CHK("read clear", 5'h0, rd[4:0])
        $display("presence and shutdown done");
        sense(77, 77);
        for (int i = 0; i < 20; i++)
            sense($random(seed) % 1000, $random(seed) % 1000);
        sense(300, 100);
        axr(pack_sup_pkg::ADDR_COUNT);
        `CHK("counter", cnt_exp, rd)
        $display("sense done");
        `CHK("pull-up off", 1'h0, trip_pullup_en)
        axw(pack_sup_pkg::ADDR_IRQ_MASK, 32'h4);
        axw(pack_sup_pkg::ADDR_CTRL, 32'h3);
        wt(2);
        `CHK("pull-up on", 1'h1, trip_pullup_en)
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            remaining_capacity_value <= 16'h0101 + 16'(i == 2 ? 16'hFE : i == 3 ? 16'hFF : 0) - 16'(i == 1);
            wt(4);
            `CHK("trip pin", i == 1 || i == 2, trip_interrupt_pin_oe & ~trip_level)
        end
        `CHK("irq", 1'h1, irq)
        axr(pack_sup_pkg::ADDR_IRQ_STATUS);
        wt(2);
        `CHK("irq cleared", 2'h2, {rd[2], irq})
        $display("trip done");
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            cell_voltage <= 16'h0FA0 + 16'(i);
            wt(3);
            `CHK("balance", 1'(i), balance_enable)
        end
        sense(100, 300);
        wt(3);
        `CHK("balance discharging", 1'h0, balance_enable)
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            pack_temp <= i == 0 ? 16'sh01C3 : i == 1 ? 16'sh01C2 : i == 2 ? -16'sh1 : 16'sh0;
            wt(3);
            `CHK("inhibit", {1'(~i), 1'(i)}, {charge_inhibit, charge_fet_drive})
        end
        $display("balance and temperature done");
        test_done();
    end
endmodule // pack_supervisor_events_bench
